// >>> port_switch_model.sv
// Purpose: far side port power switches
// Assumes: a high level closes the switch
// Notes:   ideal switch, no inrush delay
`default_nettype none
module port_switch_model (
   input  wire logic [1:0] port_power_on,
   output logic      [1:0] vbus_on
);
   timeunit 1ns; timeprecision 1ns;
   assign vbus_on = port_power_on;
endmodule // port_switch_model
`default_nettype wire

// >>> rh_power_consts.vh
// Purpose: constants for the root hub power descriptor register bank
// Assumes: APB, 32-bit data, byte address = 4 x register index
// Notes:   definitions only
`ifndef RH_POWER_CONSTS_VH
`define RH_POWER_CONSTS_VH

// Register indices (command codes), byte address = index * 4
`define IDX_DESC_FIRST_RD   8'h12
`define IDX_DESC_FIRST_WR   8'h92
`define IDX_DESC_SECOND_RD  8'h13
`define IDX_DESC_SECOND_WR  8'h93
`define IDX_POWER_CMD       8'h20
`define IDX_POWER_STATE     8'h21
`define IDX_USB_STATE       8'h22

// Field positions
`define BIT_NPS             9
`define BIT_PSM             8
`define PPCM_LO             16
`define PPCM_HI             18

// Power command register bits (write one to act)
`define CMD_SET_GLOBAL      0
`define CMD_CLR_GLOBAL      1
`define CMD_SET_PORT1       2
`define CMD_CLR_PORT1       3
`define CMD_SET_PORT2       4
`define CMD_CLR_PORT2       5

// Reset values, implementation chosen
`define RST_NDP             2'h2
`define RST_NPS             1'h0
`define RST_PSM             1'h1
`define RST_PPCM            3'h0

// USB operational state code
`define USB_OPERATIONAL     2'h2

`endif

// >>> rh_power_properties.sv
// Purpose: port checks of the power descriptor bank
// Assumes: zero wait APB, index times four
// Notes:   ports lag the register by one edge
`default_nettype none
module rh_power_checker (
   input wire logic        pclk, presetn, psel, penable, pwrite, pready,
   input wire logic        pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [1:0]  port_power_on, usb_state
);
   timeunit 1ns; timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic wr_first = psel && !penable && pwrite && paddr == 12'h248;
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_once; pready |=> !pready; endproperty
   a_once: assert property (p_once) else $error("ready held");
   property p_unmap; pready && paddr == 12'h000 |-> pslverr; endproperty
   a_unmap: assert property (p_unmap) else $error("no slverr");
   property p_map; pready && paddr[11:2] == 10'h13 |-> !pslverr; endproperty
   a_map: assert property (p_map) else $error("bad slverr");
   property p_cnt;
      pready && !pwrite && paddr == 12'h048 |-> prdata[7:0] == 8'h02;
   endproperty
   a_cnt: assert property (p_cnt) else $error("bad port count");
   property p_nps; wr_first && pwdata[9] |-> ##3 port_power_on == 2'h3;
   endproperty
   a_nps: assert property (p_nps) else $error("ports off");
   property p_grp; wr_first && pwdata[9:8] == 2'h0 |->
      ##3 port_power_on[0] == port_power_on[1]; endproperty
   a_grp: assert property (p_grp) else $error("ports split");
   property p_chg;
      $changed(port_power_on) |-> $past(pready && pwrite, 2);
   endproperty
   a_chg: assert property (p_chg) else $error("stray switch");
   property p_state; pready && pwrite && paddr == 12'h080 &&
      usb_state != 2'h2 |-> ##2 $stable(port_power_on); endproperty
   a_state: assert property (p_state) else $error("cmd obeyed");
endmodule // rh_power_checker
bind root_hub_power_descriptor rh_power_checker i_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .port_power_on(port_power_on), .usb_state(usb_state));
`default_nettype wire

// >>> root_hub_power_descriptor.v
// Purpose: root hub power descriptor registers and port power switches
// Assumes: APB slave, zero wait states, pclk 10 MHz
// Notes:   switch outputs lag the power state by one edge
// How it works
// RQ1: Flag bit 9 set powers every port always, clear makes ports switched.
// RQ2: With flag clear, bit 8 picks global or per-port switching.
// RQ3: Bit 8 has no effect while the flag is set.
// RQ4: Mode bit 0 switches all ports together as one group.
// RQ5: Mode 1 and mask set: port obeys only single-port power requests.
// RQ6: Mode 1 and mask clear: port obeys only all-ports power requests.
// RQ7: Bits 1..0 report port count, at most 2; bits 7..2 read zero.
// RQ8: Second register reads at code 13 and writes at code 93.
// RQ9: Second register reset values are chosen by the implementation.
// RQ10: First register reads at code 12 and writes at code 92.
// RQ11: Descriptor writes work in any USB state, status only operational.
// RQ12: Software accesses each register as a full 32-bit word.
// RQ13: Each port switch is derived from flag, mode, mask and power state.
//
// The APB interface to the registers was decided locally.
`default_nettype none

module root_hub_power_descriptor (
   // APB
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Port power switches
   output reg  [1:0]  port_power_on,
   // Controller USB state
   input  wire [1:0]  usb_state
);
`include "rh_power_consts.vh"

   reg        ports_always_powered_flag;
   reg        switching_granularity_bit;
   reg [1:0]  downstream_port_count;
   reg [2:0]  per_port_power_select_bits;
   reg        global_power_reg;
   reg [1:0]  port_power_reg;
   reg [1:0]  port_power_next;
   reg [31:0] rdata_next;
   reg        err_next;

   wire [9:0] word_idx = paddr[11:2];
   wire       setup    = psel & ~penable;
   wire       wr_acc   = psel & penable & pwrite & pready;
   wire [1:0] port_mask = per_port_power_select_bits[1:0];

   // Status write gate, kept for the operational-state restriction
   wire       status_ok = (usb_state == `USB_OPERATIONAL); // RQ11

   wire hit_a_rd = (word_idx == {2'h0, `IDX_DESC_FIRST_RD});   // RQ10
   wire hit_a_wr = (word_idx == {2'h0, `IDX_DESC_FIRST_WR});   // RQ10
   wire hit_b_rd = (word_idx == {2'h0, `IDX_DESC_SECOND_RD});  // RQ8
   wire hit_b_wr = (word_idx == {2'h0, `IDX_DESC_SECOND_WR});  // RQ8
   wire hit_cmd  = (word_idx == {2'h0, `IDX_POWER_CMD});
   wire hit_pst  = (word_idx == {2'h0, `IDX_POWER_STATE});
   wire hit_usb  = (word_idx == {2'h0, `IDX_USB_STATE});

   // Read mux and error decode, full words only
   always @* begin // RQ12
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      if (hit_a_rd || hit_a_wr) begin
         rdata_next[`BIT_NPS] = ports_always_powered_flag;
         rdata_next[`BIT_PSM] = switching_granularity_bit;
         rdata_next[1:0]      = downstream_port_count; // RQ7
      end else if (hit_b_rd || hit_b_wr) begin
         rdata_next[`PPCM_HI:`PPCM_LO] = per_port_power_select_bits;
      end else if (hit_cmd) begin
         rdata_next = 32'h0000_0000;
      end else if (hit_pst) begin
         rdata_next[1:0] = port_power_on;
         rdata_next[2]   = global_power_reg;
      end else if (hit_usb) begin
         rdata_next[1:0] = usb_state;
      end else begin
         err_next = 1'b1;
      end
   end

   // Zero-wait APB answer: pready rises in the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & err_next;
         if (setup && !pwrite) begin
            prdata <= rdata_next;
         end
      end
   end

   // Descriptor registers, writable in any USB state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ports_always_powered_flag  <= `RST_NPS;
         switching_granularity_bit  <= `RST_PSM;
         downstream_port_count      <= `RST_NDP;
         per_port_power_select_bits <= `RST_PPCM; // RQ9
      end else begin
         if (wr_acc && hit_a_wr) begin // RQ11
            ports_always_powered_flag <= pwdata[`BIT_NPS]; // RQ1
            switching_granularity_bit <= pwdata[`BIT_PSM]; // RQ2
         end
         if (wr_acc && hit_b_wr) begin // RQ8
            per_port_power_select_bits <= pwdata[`PPCM_HI:`PPCM_LO];
         end
      end
   end

   // Power requests; a port masked in per-port mode ignores global ones
   always @* begin
      port_power_next = port_power_reg;
      if (wr_acc && hit_cmd && status_ok) begin
         if (pwdata[`CMD_SET_PORT1])
            port_power_next[0] = 1'b1; // RQ5
         if (pwdata[`CMD_CLR_PORT1])
            port_power_next[0] = 1'b0; // RQ5
         if (pwdata[`CMD_SET_PORT2])
            port_power_next[1] = 1'b1; // RQ5
         if (pwdata[`CMD_CLR_PORT2])
            port_power_next[1] = 1'b0; // RQ5
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_power_reg <= 1'b0;
         port_power_reg   <= 2'h0;
      end else begin
         port_power_reg <= port_power_next;
         if (wr_acc && hit_cmd && status_ok) begin
            if (pwdata[`CMD_CLR_GLOBAL])
               global_power_reg <= 1'b0; // RQ6
            else if (pwdata[`CMD_SET_GLOBAL])
               global_power_reg <= 1'b1; // RQ6
         end
      end
   end

   // Switch outputs registered so they come straight from flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_power_on <= 2'h0;
      end else if (ports_always_powered_flag) begin
         port_power_on <= 2'h3; // RQ1 RQ3
      end else if (!switching_granularity_bit) begin
         port_power_on <= {2{global_power_reg}}; // RQ4 RQ2
      end else begin
         // Per port: mask picks its own state or the global one
         port_power_on <= (port_mask & port_power_reg) |
                          (~port_mask & {2{global_power_reg}}); // RQ13
      end
   end

endmodule // root_hub_power_descriptor

`default_nettype wire

// >>> tb_root_hub_power_descriptor.sv
// Purpose: bench for the power descriptor bank
// Assumes: byte address is four times the index
// Notes:   extra idle edge lets the switches settle
`default_nettype none
module tb_root_hub_power_descriptor;
   timeunit 1ns; timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er;
   logic [1:0] usb_state = 2'h0, port_power_on, vbus;
   int n_errors = 0, samples_checked = 0;
   always #50 pclk = ~pclk;
   root_hub_power_descriptor i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_power_on(port_power_on), .usb_state(usb_state));
   port_switch_model i_sw (.port_power_on(port_power_on), .vbus_on(vbus));
   task end_of_test;
      if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      k = 0;
      // Look mid-cycle: the value then is what the next rising edge sees
      do begin @(negedge pclk); k++; end while (pready !== 1'b1 && k < 9);
      if (pready !== 1'b1) begin n_errors++; end_of_test; end
      rd = prdata; er = pslverr;
      @(posedge pclk);
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] m, e);
      xfer(0, a, 0); chk("read", rd & m, e);
   endtask
   task pw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
      xfer(1, a, d);
      @(negedge pclk);
      chk("ports", {30'h0, vbus}, {30'h0, e});
      @(posedge pclk);
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      rdc(12'h048, 32'h3FF, 32'h102);
      rdc(12'h04C, 32'h70000, 32'h0);
      pw(12'h248, 32'h0, 2'h0);
      rdc(12'h048, 32'h3FF, 32'h002);
      pw(12'h080, 32'h1, 2'h0);
      usb_state <= 2'h2;
      pw(12'h080, 32'h1, 2'h3);
      pw(12'h080, 32'h8, 2'h3);
      pw(12'h080, 32'h2, 2'h0);
      pw(12'h24C, 32'h10000, 2'h0);
      rdc(12'h04C, 32'h70000, 32'h10000);
      pw(12'h248, 32'h100, 2'h0);
      pw(12'h080, 32'h1, 2'h2);
      pw(12'h080, 32'h4, 2'h3);
      pw(12'h080, 32'h2, 2'h1);
      pw(12'h080, 32'h10, 2'h1);
      pw(12'h248, 32'h300, 2'h3);
      pw(12'h248, 32'h200, 2'h3);
      pw(12'h048, 32'h0, 2'h3);
      rdc(12'h048, 32'h3FF, 32'h202);
      xfer(0, 12'h000, 0); chk("slverr", {31'h0, er}, 32'h1);
      end_of_test;
   end
endmodule // tb_root_hub_power_descriptor
`default_nettype wire
